// ### rtl/swm_ctrl.sv
// Sleep/wake, interrupt, wetting and thermal control of the switch monitor.
// Assumes switch, wake, select, thermal and supply levels arrive asynchronously,
// and the link clock only runs while select is low.
`timescale 1ns/1ps
module swm_ctrl #(
    parameter int INT_BASE = swm_pkg::INT_BASE_TICKS,
    parameter int SCAN_BASE = swm_pkg::SCAN_BASE_TICKS,
    parameter int WET_LEN = swm_pkg::WET_TICKS,
    parameter int TB_LEN = swm_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic link_si,
    output logic link_so,
    output logic link_so_oe,
    input wire logic int_line_i,
    output logic int_line_o,
    output logic int_line_oe,
    input wire logic wake_n,
    input wire logic logic_supply,
    input wire logic over_temp,
    input wire logic [swm_pkg::NUM_IN-1:0] switch_closed,
    input wire swm_pkg::swm_cfg_t cfg,
    input wire logic [4:0] analog_code,
    output logic [swm_pkg::NUM_IN-1:0] analog_select,
    output logic [swm_pkg::NUM_IN-1:0] input_active,
    output logic [swm_pkg::NUM_IN-1:0] current_high,
    output swm_pkg::swm_mode_t mode,
    output logic timebase_on
);
    import swm_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_W = NUM_IN + 5;
    // Idle pin levels, so no false select or wake edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h7, 2'h0, {NUM_IN{1'b0}}};
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [NUM_IN-1:0] sw_now;
    logic cs_f, wake_f, intl_f, therm_f, supply_f;
    logic cs_prev_reg, wake_prev_reg, intl_prev_reg;

    assign async_in = {cs_n, wake_n, int_line_i, over_temp, logic_supply, switch_closed};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= SYNC_IDLE;
            s2_reg <= SYNC_IDLE;
            s3_reg <= SYNC_IDLE;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only when the second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_reg <= SYNC_IDLE;
        end else begin
            filt_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    assign {cs_f, wake_f, intl_f, therm_f, supply_f, sw_now} = filt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_reg <= 1'b1;
            wake_prev_reg <= 1'b1;
            intl_prev_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_f;
            wake_prev_reg <= wake_f;
            intl_prev_reg <= intl_f;
        end
    end

    logic cs_fall, cs_rise, wake_fall, intl_fall;
    assign cs_fall = cs_prev_reg & ~cs_f;
    assign cs_rise = ~cs_prev_reg & cs_f;
    assign wake_fall = wake_prev_reg & ~wake_f;
    assign intl_fall = intl_prev_reg & ~intl_f;

    // ****************************************
    // Link domain: shift in, shift out
    // ****************************************
    // Select high resets the bit count; the received word then stands still
    // while the core samples it after its synchronised select rise.
    logic link_rst_n;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [WORD_W-1:0] rx_reg;
    logic full_reg, start_tgl_reg, seen_tgl_reg;
    swm_status_t tx_reg;

    assign link_rst_n = rst_n & ~cs_n;

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= '0;
        end else if (bit_cnt_reg == CNT_W'(WORD_W - 1)) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
        end
    end

    // Verdict and toggle outlive select rise until the core has looked;
    // the toggle stops a clockless frame from replaying the last command
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_reg <= 1'b0;
            start_tgl_reg <= 1'b0;
        end else begin
            full_reg <= (bit_cnt_reg == CNT_W'(WORD_W - 1));
            start_tgl_reg <= start_tgl_reg ^ (bit_cnt_reg == '0);
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= {rx_reg[WORD_W-2:0], link_si};
        end
    end

    assign link_so = tx_reg[CNT_W'(WORD_W - 1) - bit_cnt_reg];
    assign link_so_oe = ~cs_n;

    // ****************************************
    // Frame decode in the core domain
    // ****************************************
    logic frame_ok, status_read, sleep_cmd;
    assign frame_ok = cs_rise & full_reg & (start_tgl_reg ^ seen_tgl_reg);
    assign status_read = frame_ok & (rx_reg[CMD_HI:CMD_LO] == CMD_STATUS);
    assign sleep_cmd = frame_ok & (rx_reg[CMD_HI:CMD_LO] == CMD_SLEEP);

    // ****************************************
    // Timebase
    // ****************************************
    logic [TB_CNT_W-1:0] tb_cnt_reg;
    logic tick;
    swm_mode_t mode_reg;
    assign timebase_on = 1'b1; // Interrupt timer always runs in sleep
    assign tick = (tb_cnt_reg == TB_CNT_W'(TB_LEN - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_reg <= '0;
        end else if (tick) begin
            tb_cnt_reg <= '0;
        end else begin
            tb_cnt_reg <= tb_cnt_reg + TB_CNT_W'(1);
        end
    end

    // ****************************************
    // Sleep timers and mode
    // ****************************************
    swm_sleep_t codes_reg;
    logic [INT_CNT_W-1:0] int_cnt_reg, int_limit;
    logic [SCAN_CNT_W-1:0] scan_cnt_reg, scan_limit;
    logic [7:0] win_cnt_reg;
    logic [NUM_IN-1:0] ref_reg;
    logic int_exp, scan_exp, win_end, scan_diff, pin_wake;
    logic wake_any;

    assign int_limit = INT_CNT_W'(INT_BASE) << codes_reg.int_code;
    assign scan_limit = SCAN_CNT_W'(SCAN_BASE) << (codes_reg.scan_code - 3'h1);
    assign int_exp = (mode_reg != SWM_NORMAL) & tick & (int_cnt_reg == int_limit - 1'b1);
    assign scan_exp = (mode_reg == SWM_SLEEP) & (codes_reg.scan_code != SCAN_OFF)
                    & tick & (scan_cnt_reg == scan_limit - 1'b1);
    assign win_end = (mode_reg == SWM_SCAN) & tick & (win_cnt_reg == 8'(WINDOW_TICKS - 1));
    assign scan_diff = |((sw_now ^ ref_reg) & cfg.wake_en);
    // Select and interrupt-line wakes need the logic supply
    assign pin_wake = wake_fall | (supply_f & cs_fall)
                    | (supply_f & wake_f & intl_fall & ~int_line_oe);
    assign wake_any = int_exp | pin_wake | (win_end & scan_diff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= SWM_NORMAL; // Power-on reset always lands in Normal
        end else begin
            case (mode_reg)
                SWM_NORMAL: begin
                    if (sleep_cmd) begin
                        mode_reg <= SWM_SLEEP;
                    end
                end
                SWM_SLEEP: begin
                    if (wake_any) begin
                        mode_reg <= SWM_NORMAL;
                    end else if (scan_exp) begin
                        mode_reg <= SWM_SCAN;
                    end
                end
                SWM_SCAN: begin
                    if (wake_any) begin
                        mode_reg <= SWM_NORMAL;
                    end else if (win_end) begin
                        mode_reg <= SWM_SLEEP;
                    end
                end
                default: mode_reg <= SWM_NORMAL;
            endcase
        end
    end
    assign mode = mode_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            codes_reg <= '0;
        end else if (sleep_cmd && mode_reg == SWM_NORMAL) begin
            codes_reg <= {rx_reg[INT_CODE_HI:INT_CODE_LO], rx_reg[SCAN_CODE_HI:SCAN_CODE_LO]};
        end
    end

    // Timers stay cleared in Normal so each sleep starts a full period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt_reg <= '0;
        end else if (mode_reg == SWM_NORMAL || int_exp) begin
            int_cnt_reg <= '0;
        end else if (tick) begin
            int_cnt_reg <= int_cnt_reg + INT_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt_reg <= '0;
        end else if (mode_reg != SWM_SLEEP || scan_exp) begin
            scan_cnt_reg <= '0;
        end else if (tick) begin
            scan_cnt_reg <= scan_cnt_reg + SCAN_CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_reg <= '0;
        end else if (mode_reg != SWM_SCAN) begin
            win_cnt_reg <= '0;
        end else if (tick) begin
            win_cnt_reg <= win_cnt_reg + 8'h01;
        end
    end

    // ****************************************
    // Switch reference and interrupt
    // ****************************************
    // Reference tracks live state in Normal and freezes through sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg <= '0;
        end else if (mode_reg == SWM_NORMAL) begin
            ref_reg <= sw_now;
        end
    end

    logic [NUM_IN-1:0] sw_change;
    logic therm_hot, therm_rise, therm_prev_reg;
    logic int_set, int_reg, frame_change_reg, therm_flag_reg;

    assign sw_change = (sw_now ^ ref_reg) & cfg.wake_en;
    assign therm_hot = therm_f & (mode_reg == SWM_NORMAL);
    assign therm_rise = therm_hot & ~therm_prev_reg;
    assign int_set = ((mode_reg == SWM_NORMAL) & (|sw_change))
                   | int_exp
                   | (win_end & scan_diff)
                   | therm_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            therm_prev_reg <= 1'b0;
        end else begin
            therm_prev_reg <= therm_hot;
        end
    end

    // Remembers a change seen while select was low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_change_reg <= 1'b0;
        end else if (cs_f) begin
            frame_change_reg <= 1'b0;
        end else if (int_set) begin
            frame_change_reg <= 1'b1;
        end
    end

    // A new event beats the acknowledge in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_reg <= 1'b0;
        end else if (int_set) begin
            int_reg <= 1'b1;
        end else if (status_read && !frame_change_reg) begin
            int_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            therm_flag_reg <= 1'b0;
        end else if (therm_hot) begin
            therm_flag_reg <= 1'b1;
        end else if (cs_rise) begin
            therm_flag_reg <= 1'b0;
        end
    end

    assign int_line_o = 1'b0;
    assign int_line_oe = int_reg;

    // ****************************************
    // Output word snapshot
    // ****************************************
    // Each frame is decoded once: remember the toggle last looked at
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_tgl_reg <= 1'b0;
        end else if (cs_rise) begin
            seen_tgl_reg <= start_tgl_reg;
        end
    end

    // Taken on select fall; tx_reg is stable for the whole frame

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg <= '0;
        end else if (cs_fall && mode_reg != SWM_NORMAL) begin
            tx_reg <= '0; // Controller drops this frame
        end else if (cs_fall) begin
            tx_reg <= {therm_flag_reg, int_reg, sw_now & ~analog_select};
        end
    end

    // ****************************************
    // Inputs, wetting current and analog select
    // ****************************************
    // Settings are ports held by the command block, untouched by sleep
    logic force_low;
    assign force_low = therm_hot; // Releases as soon as it cools

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic [WET_CNT_W-1:0] wet_cnt_reg;
            logic wet_phase;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    wet_cnt_reg <= '0;
                end else if (!sw_now[gi]) begin
                    wet_cnt_reg <= '0;
                end else if (tick && wet_cnt_reg != WET_CNT_W'(WET_LEN)) begin
                    wet_cnt_reg <= wet_cnt_reg + WET_CNT_W'(1);
                end
            end

            assign wet_phase = ~cfg.wet_timer_en[gi]
                             | (wet_cnt_reg != WET_CNT_W'(WET_LEN));

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    input_active[gi] <= 1'b0;
                    current_high[gi] <= 1'b0;
                end else begin
                    // Inputs float in sleep except inside a scan window
                    input_active[gi] <= ~cfg.tri_state[gi] & (mode_reg != SWM_SLEEP);
                    current_high[gi] <= cfg.metallic[gi] & sw_now[gi] & wet_phase
                                      & ~force_low;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    analog_select[gi] <= 1'b0;
                end else begin
                    analog_select[gi] <= (analog_code != ANALOG_SEL_NONE)
                                       && (analog_code == 5'(gi + 1));
                end
            end
        end
    endgenerate
endmodule

// ### inc/swm_pkg.sv
// Constants, types and timing for the switch monitor sleep/wake controller.
// Assumes one 200 MHz core clock and a serial link clocked by its own pin.
// Summary of operation
// - Sleep entered only by valid sleep command
// - Normal-mode settings survive sleep unchanged
// - Wake on change, timer, pins, reset
// - Interrupt/select wake need logic supply present
// - First output frame after select wake invalid
// - Sleep command carries interrupt and scan codes
// - Interrupt period doubles, 32 ms to 4.096 s
// - Interrupt timer expiry interrupts and wakes
// - Scan code zero disables, else 1-64 ms
// - Scan activates inputs 125 us, samples switches
// - Changed enabled switch interrupts and wakes
// - Unchanged scan restarts timer, tri-states inputs
// - Sleep timers idle in Normal mode
// - Enabled change holds interrupt until status read
// - Change during select keeps interrupt asserted
// - Disabled inputs never latch transitions
// - Metallic timed input: high current 20 ms
// - Timer disabled: current continuous while closed
// - Over-temperature in Normal mode: interrupt, flag, force low current
// - Thermal flag clears on select rise if cool
// - Cooling restores programmed current settings
// - Analog select zero connects no input
// - Status bit: open reads 0, closed 1, analog-selected input 0
package swm_pkg;
    localparam int NUM_IN = 22;
    localparam int WORD_W = 24;
    localparam int CNT_W = 5;

    // ****************************************
    // Command layout
    // ****************************************
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 16;
    localparam logic [7:0] CMD_STATUS = 8'h00;
    localparam logic [7:0] CMD_SLEEP = 8'h0C;
    localparam int INT_CODE_HI = 5;
    localparam int INT_CODE_LO = 3;
    localparam int SCAN_CODE_HI = 2;
    localparam int SCAN_CODE_LO = 0;
    localparam logic [2:0] SCAN_OFF = 3'h0;
    localparam logic [4:0] ANALOG_SEL_NONE = 5'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int INT_BASE_MS = 32;
    localparam int SCAN_BASE_MS = 1;
    localparam int WINDOW_US = 125;
    localparam int WET_MS = 20;
    localparam int INT_BASE_TICKS = INT_BASE_MS * 1000000 / TICK_NS;
    localparam int SCAN_BASE_TICKS = SCAN_BASE_MS * 1000000 / TICK_NS;
    localparam int WINDOW_TICKS = WINDOW_US * 1000 / TICK_NS;
    localparam int WET_TICKS = WET_MS * 1000000 / TICK_NS;
    localparam int INT_CNT_W = 23;
    localparam int SCAN_CNT_W = 17;
    localparam int WET_CNT_W = 15;
    localparam int TB_CNT_W = 8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SWM_NORMAL,
        SWM_SLEEP,
        SWM_SCAN
    } swm_mode_t;

    typedef struct packed {
        logic [NUM_IN-1:0] wake_en;
        logic [NUM_IN-1:0] metallic;
        logic [NUM_IN-1:0] wet_timer_en;
        logic [NUM_IN-1:0] tri_state;
    } swm_cfg_t;

    typedef struct packed {
        logic therm_flag;
        logic int_flag;
        logic [NUM_IN-1:0] closed;
    } swm_status_t;

    typedef struct packed {
        logic [2:0] int_code;
        logic [2:0] scan_code;
    } swm_sleep_t;
endpackage

// ### bench/swm_ctrl_chk.sv
// Assertions for the switch monitor sleep/wake controller.
// Assumes binding to swm_ctrl; sees its ports only.
`timescale 1ns/1ps
module swm_ctrl_chk #(
    parameter int TB_LEN = swm_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic wake_n,
    input wire logic over_temp,
    input wire logic int_line_oe,
    input wire logic [4:0] analog_code,
    input wire logic [swm_pkg::NUM_IN-1:0] analog_select,
    input wire logic [swm_pkg::NUM_IN-1:0] input_active,
    input wire logic [swm_pkg::NUM_IN-1:0] current_high,
    input wire swm_pkg::swm_cfg_t cfg,
    input wire swm_pkg::swm_mode_t mode
);
    import swm_pkg::*;
    // Window edges may fall anywhere inside a tick, so allow one tick either way
    localparam int WIN_MIN = (WINDOW_TICKS - 1) * TB_LEN;
    localparam int WIN_MAX = (WINDOW_TICKS + 1) * TB_LEN;
    logic [15:0] scan_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt <= '0;
        end else if (mode == SWM_SCAN) begin
            scan_cnt <= scan_cnt + 16'h0001;
        end else begin
            scan_cnt <= '0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sleep_by_cmd: assert property (
        mode == SWM_NORMAL ##1 mode == SWM_SLEEP |-> cs_n && $past(cs_n, 3))
        else $error("sleep without finished frame");
    a_sleep_quiet: assert property (
        mode == SWM_SLEEP && $past(mode) == SWM_SLEEP |-> input_active == '0)
        else $error("inputs driven in sleep");
    a_scan_drive: assert property (
        mode == SWM_SCAN && $past(mode) == SWM_SCAN |-> input_active == ~cfg.tri_state)
        else $error("scan inputs not as programmed");
    a_scan_len: assert property (
        mode == SWM_SCAN ##1 mode == SWM_SLEEP |-> $past(scan_cnt) >= 16'(WIN_MIN - 1))
        else $error("scan window short");
    a_scan_max: assert property (
        mode == SWM_SCAN |-> scan_cnt < 16'(WIN_MAX))
        else $error("scan window long");
    a_scan_wake: assert property (
        mode == SWM_SCAN ##1 mode == SWM_NORMAL |-> ##[0:2] int_line_oe)
        else $error("scan wake without interrupt");
    a_hot_current: assert property (
        (over_temp && mode == SWM_NORMAL) [*6] |-> current_high == '0)
        else $error("high current while hot");
    a_hot_irq: assert property (
        mode == SWM_NORMAL && $rose(over_temp) |-> ##[1:8] int_line_oe)
        else $error("no interrupt on overheat");
    a_mux_none: assert property (
        (analog_code == ANALOG_SEL_NONE) [*4] |-> analog_select == '0)
        else $error("input selected for code zero");
    a_int_hold: assert property (
        $fell(int_line_oe) |-> $past(cs_n, 3) && $past(cs_n))
        else $error("interrupt released inside frame");
    a_wake_pin: assert property (
        mode != SWM_NORMAL && $fell(wake_n) |-> ##[1:8] mode == SWM_NORMAL)
        else $error("no wake on pin");
endmodule
bind swm_ctrl swm_ctrl_chk #(.TB_LEN(TB_LEN)) chk_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .wake_n(wake_n), .over_temp(over_temp), .int_line_oe(int_line_oe),
    .analog_code(analog_code), .analog_select(analog_select), .input_active(input_active),
    .current_high(current_high),
    .cfg(cfg), .mode(mode));

// ### bench/swm_mcu.sv
// Microcontroller model on the serial link.
// Assumes the bench calls xfer a small delay after a core clock edge.
`timescale 1ns/1ps
module swm_mcu (
    output logic link_clk,
    output logic cs_n,
    output logic link_si,
    input wire logic link_so
);
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        link_si = 1'b0;
    end
    // Link clock 6 ns, running only inside a frame; MSB first both ways
    task automatic xfer(input logic [23:0] cmd, output logic [23:0] rsp);
        cs_n = 1'b0;
        #31.3;
        for (int i = 23; i >= 0; i--) begin
            link_si = cmd[i];
            #1.5 rsp[i] = link_so;
            #1.5 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        #3 cs_n = 1'b1;
        // Released data line must not keep showing the last bit
        link_si = ~link_si;
        #30;
    endtask
endmodule

// ### bench/swm_ctrl_test.sv
// Self-checking bench for the switch monitor sleep/wake controller.
// Assumes the microcontroller model and a shortened timebase.
`timescale 1ns/1ps
module swm_ctrl_test;
    import swm_pkg::*;
    localparam int TB = 4;
    typedef struct packed {
        logic [NUM_IN-1:0] sw;
        logic [4:0] code;
        logic [NUM_IN-1:0] sel;
    } swm_row_t;
    swm_row_t rows [4] = '{'{22'h000000, 5'h00, 22'h000000}, '{22'h3FFFFF, 5'h01, 22'h000001},
        '{22'h2AAAAA, 5'h16, 22'h200000}, '{22'h155555, 5'h03, 22'h000004}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wake_n = 1'b1;
    logic supply = 1'b1;
    logic hot = 1'b0;
    logic pull = 1'b0;
    logic [4:0] sel_code = 5'h00;
    logic [NUM_IN-1:0] sw = '0;
    swm_cfg_t cfg = '{'0, '1, 22'h3FFFFB, '0};
    logic link_clk, cs_n, link_si, link_so, link_so_oe, int_line_o, int_line_oe, timebase_on;
    logic [NUM_IN-1:0] analog_select, input_active, current_high;
    swm_mode_t mode;
    logic [23:0] rsp;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    // Open-drain interrupt wire with pull-up
    wire int_wire = (int_line_oe ? int_line_o : 1'b1) & ~pull;
    always #2.5 clk = ~clk;
    swm_mcu mcu (.link_clk(link_clk), .cs_n(cs_n), .link_si(link_si), .link_so(link_so));
    swm_ctrl #(.INT_BASE(8), .SCAN_BASE(4), .WET_LEN(10), .TB_LEN(TB)) dut (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cs_n(cs_n), .link_si(link_si),
        .link_so(link_so), .link_so_oe(link_so_oe), .int_line_i(int_wire),
        .int_line_o(int_line_o), .int_line_oe(int_line_oe), .wake_n(wake_n),
        .logic_supply(supply), .over_temp(hot), .switch_closed(sw), .cfg(cfg),
        .analog_code(sel_code), .analog_select(analog_select), .input_active(input_active),
        .current_high(current_high), .mode(mode), .timebase_on(timebase_on));
    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded wait for a mode; cycle count left in n
    task automatic wait_mode(input swm_mode_t m, input int lim);
        n = 0;
        while (mode !== m && n < lim) begin
            cyc(1);
            n++;
        end
        chk(n < lim, "mode wait timed out");
        if (n >= lim) finish_test();
    endtask
    initial begin
        cyc(2);
        rst_n = 1'b1;
        cyc(6);
        foreach (rows[i]) begin
            sw = rows[i].sw;
            sel_code = rows[i].code;
            cyc(6);
            mcu.xfer(24'h000000, rsp);
            cyc(1);
            chk(analog_select === rows[i].sel, "mux select");
            chk(rsp[21:0] === (rows[i].sw & ~rows[i].sel), "status word");
            chk(mode === SWM_NORMAL, "mode after status");
        end
        sw = '0;
        sel_code = 5'h00;
        cyc(6);
        sw[0] = 1'b1;
        cyc(8);
        chk(int_line_oe === 1'b0, "masked change");
        cfg.wake_en[0] = 1'b1;
        sw[0] = 1'b0;
        cyc(8);
        chk(int_line_oe === 1'b1, "change irq");
        fork
            mcu.xfer(24'h000000, rsp);
            begin
                #80 sw[0] = 1'b1;
                chk(link_so_oe === 1'b1, "output not driven in frame");
            end
        join
        cyc(10);
        chk(int_line_oe === 1'b1, "change in frame");
        mcu.xfer(24'h000000, rsp);
        cyc(10);
        chk(int_line_oe === 1'b0, "read clears");
        sw[2:1] = 2'b11;
        cyc(10);
        chk(current_high[2:1] === 2'b11, "high current");
        cyc(50);
        chk(current_high[2:1] === 2'b10, "timed drop");
        hot = 1'b1;
        cyc(10);
        chk(current_high[2] === 1'b0 && int_line_oe === 1'b1, "hot");
        mcu.xfer(24'h000000, rsp);
        chk(rsp[23] === 1'b1, "thermal flag");
        cyc(1);
        hot = 1'b0;
        cyc(10);
        chk(current_high[2] === 1'b1, "current restored");
        mcu.xfer(24'h000000, rsp);
        chk(rsp[23] === 1'b1, "flag held");
        mcu.xfer(24'h000000, rsp);
        chk(rsp[23] === 1'b0, "flag cleared");
        cyc(1);
        sw[2:1] = 2'b00;
        for (int c = 0; c < 3; c++) begin
            cyc(2);
            mcu.xfer({16'h0C00, 2'b00, c[2:0], 3'b000}, rsp);
            wait_mode(SWM_SLEEP, 20);
            wait_mode(SWM_NORMAL, 2000);
            chk(n > (8 << c) * TB - 8 && n < (8 << c) * TB + 8, "wake period");
            chk(int_line_oe === 1'b1, "timer irq");
            mcu.xfer(24'h000000, rsp);
        end
        cyc(300);
        chk(mode === SWM_NORMAL && int_line_oe === 1'b0, "timers idle");
        chk(timebase_on === 1'b1, "timebase stopped");
        mcu.xfer(24'h0C0039, rsp);
        wait_mode(SWM_SCAN, 100);
        cyc(2);
        chk(input_active === ~cfg.tri_state, "scan drive");
        wait_mode(SWM_SLEEP, 600);
        cyc(2);
        chk(input_active === '0, "scan release");
        sw[0] = 1'b0;
        wait_mode(SWM_NORMAL, 1200);
        chk(int_line_oe === 1'b1, "scan irq");
        cyc(2);
        chk(input_active === ~cfg.tri_state, "settings kept");
        mcu.xfer(24'h0C0038, rsp);
        cyc(300);
        chk(mode === SWM_SLEEP, "no scan");
        wake_n = 1'b0;
        wait_mode(SWM_NORMAL, 10);
        mcu.xfer(24'h0C0038, rsp);
        cyc(2);
        supply = 1'b0;
        cyc(1);
        mcu.xfer(24'h000000, rsp);
        cyc(2);
        supply = 1'b1;
        pull = 1'b1;
        cyc(4);
        pull = 1'b0;
        cyc(4);
        chk(mode === SWM_SLEEP, "gated wake");
        wake_n = 1'b1;
        cyc(4);
        mcu.xfer(24'h000000, rsp);  // Word after select wake is thrown away
        cyc(6);
        chk(mode === SWM_NORMAL, "select wake");
        mcu.xfer(24'h0C0038, rsp);
        cyc(2);
        pull = 1'b1;
        wait_mode(SWM_NORMAL, 10);
        pull = 1'b0;
        mcu.xfer(24'h0C0038, rsp);
        cyc(2);
        rst_n = 1'b0;
        cyc(2);
        chk(mode === SWM_NORMAL && int_line_oe === 1'b0, "power-on wake");
        rst_n = 1'b1;
        cyc(4);
        finish_test();
    end
endmodule
